/* hdl/dpv_line_out.sv */
// Dual-pixel line video output: sequences acquired lines onto the video link.
// Assumes pixel pairs arrive on mclk from the readout path, config levels come
// from the command decoder on mclk, and pix_clk is the free link pixel clock.
// How it works
// RULE_01: Line-valid stays low on every pixel cycle with no valid line data.
// RULE_02: A line starts only after its acquisition-done event has crossed over.
// RULE_03: First cycle raises line-valid and carries pixels one and two in lanes.
// RULE_04: Each later cycle keeps line-valid high with the next pair, no gaps. The code repeats the last pair when the FIFO runs dry mid-line.
// RULE_05: A line lasts 512 cycles on 1K sensors and 1024 on 2K sensors.
// RULE_06: After the last pair, line-valid drops low.
// RULE_07: In 8-bit depth only eight bits per pixel are sent, upper bits zero.
// RULE_08: Exposure-active rises at exposure start and falls at exposure end.
// RULE_09: In edge-controlled mode exposure-active is low during charge transfer.
// RULE_10: Host changes modes over serial; decoder here supplies config levels.
// RULE_11: Pixel clock is 20 MHz slow variant, 31.25 MHz fast variant.
// RULE_12: Link outputs launch on each falling edge of the pixel clock.
// RULE_13: Data-valid is held permanently high; the receiver ignores it.
// RULE_14: Receiver takes pixel data only while line-valid is high.
// RULE_15: After reset, line-valid and exposure-active stay low until a line is acquired.
`timescale 1ns/1ps
`default_nettype none
`include "dpv_map.svh"
// ==========================================================================
// Dual-clock FIFO; write side on wclk rising, read side on rclk falling
// ==========================================================================
module dpv_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = `DPV_FIFO_DEPTH
) (
    input  wire logic             wclk,     // Write clock.
    input  wire logic             wrst_n,   // Write reset, active low.
    input  wire logic             w_valid,  // Write word offered.
    output logic                  w_ready,  // Room for a word.
    input  wire logic [WIDTH-1:0] w_data,   // Write word.
    input  wire logic             rclk,     // Read clock, falling edge used.
    input  wire logic             rrst_n,   // Read reset, active low.
    output logic                  r_valid,  // Word available.
    input  wire logic             r_ready,  // Reader takes the word.
    output logic [WIDTH-1:0]      r_data    // Read word.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wbin_r, wbin_nxt, wgray_r, rbin_r, rbin_nxt, rgray_r;
    logic [AW:0]      rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r, rbin_w, wbin_rd;
    logic             wrdy_r, wrdy_nxt;
    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction
    // Pointers cross as gray code through two flops, so no multi-bit skew is seen.
    // Ready is registered room after this edge's write, judged against the older
    // read pointer, so it never offers a slot that is already gone. [RULE_04]
    always_comb begin
        rbin_w   = g2b(rg_s2_r);
        wbin_rd  = g2b(wg_s2_r);
        w_ready  = wrdy_r;
        r_valid  = (wbin_rd != rbin_r);
        r_data   = mem[rbin_r[AW-1:0]];
        wbin_nxt = wbin_r + {{AW{1'b0}}, (w_valid && w_ready)};
        rbin_nxt = rbin_r + {{AW{1'b0}}, (r_valid && r_ready)};
        wrdy_nxt = (wbin_nxt - rbin_w) != DEPTH[AW:0];
    end
    // Write side registers and storage.
    always_ff @(posedge wclk or negedge wrst_n) begin
        if (!wrst_n) begin
            wbin_r  <= '0;
            wgray_r <= '0;
            rg_s1_r <= '0;
            rg_s2_r <= '0;
            wrdy_r  <= 1'b0;
        end else begin
            wbin_r  <= wbin_nxt;
            wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
            rg_s1_r <= rgray_r;
            rg_s2_r <= rg_s1_r;
            wrdy_r  <= wrdy_nxt;
        end
    end
    always_ff @(posedge wclk) begin
        if (w_valid && w_ready) begin
            mem[wbin_r[AW-1:0]] <= w_data;
        end
    end
    // Read side registers, falling edge to match the link launch edge.
    always_ff @(negedge rclk or negedge rrst_n) begin
        if (!rrst_n) begin
            rbin_r  <= '0;
            rgray_r <= '0;
            wg_s1_r <= '0;
            wg_s2_r <= '0;
        end else begin
            rbin_r  <= rbin_nxt;
            rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
            wg_s1_r <= wgray_r;
            wg_s2_r <= wg_s1_r;
        end
    end
endmodule
// ==========================================================================
// Top: line sequencer and exposure-active output
// ==========================================================================
module dpv_line_out
    import dpv_pkg::*;
#(
    parameter int FIFO_DEPTH = `DPV_FIFO_DEPTH
) (
    input  wire logic      mclk,                // System clock, 50 MHz.
    input  wire logic      arst_n,              // Async reset, active low.
    input  wire logic      pix_clk,             // Link pixel clock.
    input  wire logic      line_acq_done,       // Pulse: a line finished acquisition.
    input  wire dpv_pair_t pix_pair,            // Pixel pair from readout.
    input  wire logic      pix_valid,           // Pixel pair offered.
    output logic           pix_ready,           // FIFO accepts the pair.
    input  wire logic      depth8,              // Level: 8-bit output depth.
    input  wire logic      sensor_2k,           // Level: 2K-pixel sensor.
    input  wire logic      edge_mode,           // Level: edge-controlled exposure.
    input  wire logic      exposure_start,      // Pulse: exposure begins.
    input  wire logic      exposure_end,        // Pulse: exposure ends.
    input  wire logic      charge_xfer,         // Level: charge transfer under way.
    output logic           exposure_active_out, // Exposure-active pin.
    output dpv_link_t      link_out,            // Framing and data on the link.
    output logic           underrun             // Sticky: FIFO ran dry mid-line.
);
    // Link clock rate in dual-pixel mode. [RULE_11]
    localparam int PCLK_KHZ = `DPV_PCLK_FAST_KHZ;
    // ======================================================================
    // System domain: line-done toggle and exposure output
    // ======================================================================
    logic acq_tog_r, acq_tog_nxt, first_r, first_nxt;
    logic expo_r, expo_nxt, exp_out_r, exp_out_nxt, fifo_w_ready;
    // Start wins over end so a back-to-back pair never loses the new exposure.
    always_comb begin
        acq_tog_nxt = acq_tog_r ^ line_acq_done;
        first_nxt   = first_r | line_acq_done;
        expo_nxt    = expo_r;
        if (exposure_end) begin
            expo_nxt = 1'b0;
        end
        if (exposure_start) begin
            expo_nxt = 1'b1;
        end
        // Gated until the first line and dropped during edge-mode transfer.
        exp_out_nxt = expo_nxt && first_r && !(edge_mode && charge_xfer); // [RULE_08] [RULE_09] [RULE_15]
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            acq_tog_r <= 1'b0;
            first_r   <= 1'b0;
            expo_r    <= 1'b0;
            exp_out_r <= 1'b0;
        end else begin
            acq_tog_r <= acq_tog_nxt;
            first_r   <= first_nxt;
            expo_r    <= expo_nxt;
            exp_out_r <= exp_out_nxt;
        end
    end
    // Ready is the FIFO's own ready flop, so a taken word is always stored.
    assign pix_ready           = fifo_w_ready;
    assign exposure_active_out = exp_out_r;
    a_exp_start_rise: assert property (@(posedge mclk) disable iff (!arst_n)
        exposure_start && first_r && !(edge_mode && charge_xfer) |=> exposure_active_out) // [RULE_08]
        else $error("exposure-active did not rise at exposure start");
    a_exp_xfer_low: assert property (@(posedge mclk) disable iff (!arst_n)
        edge_mode && charge_xfer |=> !exposure_active_out) // [RULE_09]
        else $error("exposure-active high during edge-mode charge transfer");
    a_exp_before_first: assert property (@(posedge mclk) disable iff (!arst_n)
        !first_r |=> !exposure_active_out) // [RULE_15]
        else $error("exposure-active high before the first line");
    // ======================================================================
    // Link domain: reset release, config and event crossings
    // ======================================================================
    logic [1:0] prst_r;
    logic       prst_n;
    logic       tog_s1_r, tog_s2_r, tog_s3_r, d8_s1_r, d8_s2_r, s2k_s1_r, s2k_s2_r;
    // Reset asserts at once and releases on the link clock, two flops deep.
    always_ff @(negedge pix_clk or negedge arst_n) begin
        if (!arst_n) begin
            prst_r <= 2'b00;
        end else begin
            prst_r <= {prst_r[0], 1'b1};
        end
    end
    assign prst_n = prst_r[1];
    // Config levels come from the command decoder and are only sampled
    // between lines, so a two-flop crossing is enough. [RULE_10]
    always_ff @(negedge pix_clk or negedge prst_n) begin
        if (!prst_n) begin
            {tog_s1_r, tog_s2_r, tog_s3_r, d8_s1_r, d8_s2_r, s2k_s1_r, s2k_s2_r} <= 7'h00;
        end else begin
            tog_s1_r <= acq_tog_r;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
            d8_s1_r  <= depth8;
            d8_s2_r  <= d8_s1_r;
            s2k_s1_r <= sensor_2k;
            s2k_s2_r <= s2k_s1_r;
        end
    end
    // ======================================================================
    // Pixel FIFO between readout and link
    // ======================================================================
    logic      f_valid, f_pop;
    dpv_pair_t f_data;
    dpv_fifo #(
        .WIDTH (2 * `DPV_PIX_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .wclk    (mclk),
        .wrst_n  (arst_n),
        .w_valid (pix_valid && pix_ready),
        .w_ready (fifo_w_ready),
        .w_data  (pix_pair),
        .rclk    (pix_clk),
        .rrst_n  (prst_n),
        .r_valid (f_valid),
        .r_ready (f_pop),
        .r_data  (f_data)
    );
    // ======================================================================
    // Link domain: line sequencer, launched on the falling edge
    // ======================================================================
    dpv_state_t             st_r, st_nxt;
    logic [3:0]             pend_r, pend_nxt;
    logic [`DPV_CNT_W-1:0]  cnt_r, cnt_nxt, len_r, len_nxt;
    logic                   d8_r, d8_nxt, und_r, und_nxt;
    dpv_link_t              lo_r, lo_nxt;
    logic                   acq_evt, start;
    function automatic dpv_pair_t shape(input dpv_pair_t p, input logic d8);
        dpv_pair_t q;
        q = p;
        if (d8) begin
            // Two low bits dropped, eight bits sent in the low lanes. [RULE_07]
            q.first  = {2'b00, p.first[`DPV_PIX_W-1:2]};
            q.second = {2'b00, p.second[`DPV_PIX_W-1:2]};
        end
        return q;
    endfunction
    always_comb begin
        acq_evt  = tog_s2_r ^ tog_s3_r;
        start    = (st_r == DPV_IDLE) && (pend_r != 4'h0) && f_valid; // [RULE_02]
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        len_nxt  = len_r;
        d8_nxt   = d8_r;
        und_nxt  = und_r;
        f_pop    = 1'b0;
        lo_nxt   = lo_r;
        lo_nxt.data_valid = 1'b1; // Unused in this mode, held high. [RULE_13]
        pend_nxt = pend_r + {3'b000, acq_evt} - {3'b000, start};
        case (st_r)
            DPV_IDLE: begin
                lo_nxt.line_valid = 1'b0; // [RULE_01]
                if (start) begin
                    // Length and depth are frozen for the whole line.
                    len_nxt = s2k_s2_r ? `DPV_LINE_2K : `DPV_LINE_1K; // [RULE_05]
                    d8_nxt  = d8_s2_r;
                    f_pop   = 1'b1;
                    cnt_nxt = `DPV_CNT_W'(1);
                    lo_nxt.line_valid = 1'b1; // Pixels one and two. [RULE_03]
                    lo_nxt.pair       = shape(f_data, d8_s2_r);
                    st_nxt  = DPV_SEND;
                end
            end
            DPV_SEND: begin
                if (cnt_r == len_r) begin
                    lo_nxt.line_valid = 1'b0; // [RULE_06]
                    st_nxt  = DPV_IDLE;
                end else begin
                    // No gap is allowed; a dry FIFO repeats the last pair. [RULE_04]
                    lo_nxt.line_valid = 1'b1;
                    cnt_nxt = cnt_r + `DPV_CNT_W'(1);
                    f_pop   = f_valid;
                    if (f_valid) begin
                        lo_nxt.pair = shape(f_data, d8_r);
                    end else begin
                        und_nxt = 1'b1;
                    end
                end
            end
            default: begin
                st_nxt = DPV_IDLE;
                lo_nxt.line_valid = 1'b0;
            end
        endcase
    end
    // Outputs launch on the falling edge so the receiver has half a cycle. [RULE_12]
    always_ff @(negedge pix_clk or negedge prst_n) begin
        if (!prst_n) begin
            st_r   <= DPV_IDLE;
            pend_r <= 4'h0;
            cnt_r  <= '0;
            len_r  <= `DPV_LINE_1K;
            d8_r   <= 1'b0;
            und_r  <= 1'b0;
            lo_r   <= '0;
        end else begin
            st_r   <= st_nxt;
            pend_r <= pend_nxt;
            cnt_r  <= cnt_nxt;
            len_r  <= len_nxt;
            d8_r   <= d8_nxt;
            und_r  <= und_nxt;
            lo_r   <= lo_nxt;
        end
    end
    assign link_out = lo_r;
    assign underrun = und_r;
    a_lv_rise_pend: assert property (@(negedge pix_clk) disable iff (!prst_n)
        $rose(lo_r.line_valid) |-> $past(pend_r) != 4'h0) // [RULE_02]
        else $error("line started without an acquired line");
    a_lv_first_pair: assert property (@(negedge pix_clk) disable iff (!prst_n)
        $rose(lo_r.line_valid) |-> cnt_r == `DPV_CNT_W'(1)) // [RULE_03]
        else $error("line did not begin with the first pair");
    a_lv_no_gap: assert property (@(negedge pix_clk) disable iff (!prst_n)
        lo_r.line_valid && cnt_r != len_r |=> lo_r.line_valid && cnt_r == $past(cnt_r) + 1'b1) // [RULE_04]
        else $error("gap inside a line");
    a_line_length: assert property (@(negedge pix_clk) disable iff (!prst_n)
        $fell(lo_r.line_valid) |-> $past(cnt_r) == $past(len_r)
            && ($past(len_r) == `DPV_LINE_1K || $past(len_r) == `DPV_LINE_2K)) // [RULE_05]
        else $error("line length not 512 or 1024 cycles");
    a_lv_end_low: assert property (@(negedge pix_clk) disable iff (!prst_n)
        lo_r.line_valid && cnt_r == len_r |=> !lo_r.line_valid) // [RULE_06]
        else $error("line-valid stayed high after the last pair");
    a_depth8_lanes: assert property (@(negedge pix_clk) disable iff (!prst_n)
        lo_r.line_valid && d8_r |-> lo_r.pair.first[9:8] == 2'b00 && lo_r.pair.second[9:8] == 2'b00) // [RULE_07]
        else $error("upper bits set in 8-bit depth");
    a_dval_high: assert property (@(negedge pix_clk) disable iff (!prst_n)
        $past(prst_n) |-> lo_r.data_valid) // [RULE_13]
        else $error("data-valid not held high");
    a_idle_lv_low: assert property (@(negedge pix_clk) disable iff (!prst_n)
        st_r == DPV_IDLE && !$past(start) |-> !lo_r.line_valid) // [RULE_01]
        else $error("line-valid high with no line data");
endmodule
`default_nettype wire

/* hdl/dpv_map.svh */
// Constants for the dual-pixel line video output block.
// Assumes inclusion by bare name from every file that needs offsets or counts.
`ifndef DPV_MAP_SVH
`define DPV_MAP_SVH

// ==========================================================================
// Widths, depths and line lengths
// ==========================================================================
`define DPV_PIX_W        10
`define DPV_PIX8_W       8
`define DPV_FIFO_DEPTH   8
`define DPV_LINE_1K      11'd512
`define DPV_LINE_2K      11'd1024
`define DPV_CNT_W        11

// ==========================================================================
// Pixel clock rates in kHz, slow and fast variant, and the system clock rate
// ==========================================================================
`define DPV_PCLK_SLOW_KHZ 20000
`define DPV_PCLK_FAST_KHZ 31250
`define DPV_MCLK_KHZ      50000

`endif

/* hdl/dpv_pkg.sv */
// Types shared by the dual-pixel line video output block.
// Assumes dpv_map.svh holds the numeric constants.
`include "dpv_map.svh"

package dpv_pkg;

    // Two neighbouring pixels carried in one link cycle.
    typedef struct packed {
        logic [`DPV_PIX_W-1:0] first;
        logic [`DPV_PIX_W-1:0] second;
    } dpv_pair_t;

    // Framing bits and data as they leave on the link.
    typedef struct packed {
        logic      line_valid;
        logic      data_valid;
        dpv_pair_t pair;
    } dpv_link_t;

    // Line sequencer states, one-hot.
    typedef enum logic [1:0] {
        DPV_IDLE = 2'b01,
        DPV_SEND = 2'b10
    } dpv_state_t;

endpackage

/* sim/dpv_grabber.sv */
// Frame grabber model: receives dual-pixel lines from the video link.
// Assumes link_out launches on falling pix_clk edges; it samples on rising edges.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Link receiver with line length and pixel order checks
// ==========================================================================
module dpv_grabber
    import dpv_pkg::*;
(
    input  wire logic      pix_clk,  // Link pixel clock.
    input  wire logic      arst_n,   // Reset, active low.
    input  wire dpv_link_t link,     // Link as seen at the receiver.
    input  wire logic      mode8,    // Expect 8-bit lanes.
    output var int         len_last, // Length of the last finished line.
    output var int         lines,    // Lines received.
    output var int         bad       // Bad pairs or framing seen.
);
    int        cnt;
    logic [21:0] s;

    // Pixel p of a line carries a 10-bit value made from its index.
    function automatic logic [9:0] lane(input int p, input logic m8);
        logic [9:0] v;
        v = 10'(p * 7);
        return m8 ? {2'b00, v[9:2]} : v;
    endfunction

    // Pixels count only while line-valid is high; data-valid is checked but not used to qualify.
    always @(posedge pix_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt = 0; len_last = 0; lines = 0; bad = 0;
        end else if (link.line_valid === 1'b1) begin
            if (link.data_valid !== 1'b1) bad++;
            if (link.pair.first !== lane(2 * cnt + 1, mode8)) bad++;
            if (link.pair.second !== lane(2 * cnt + 2, mode8)) bad++;
            cnt++;
        end else if (cnt != 0) begin
            len_last = cnt;
            lines++;
            cnt = 0;
        end
    end

    // A change just after the rising edge means the link is not launched on the falling edge.
    always @(posedge pix_clk) begin
        s = link;
        #2;
        if (arst_n && link !== s) bad++;
    end
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Testbench for the dual-pixel line video output block.
// Assumes dpv_line_out with its package and the grabber model are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

// ==========================================================================
// Bench top
// ==========================================================================
module testbench
    import dpv_pkg::*;
;
    logic      mclk, arst_n, pix_clk, line_acq_done, pix_valid, pix_ready;
    logic      depth8, sensor_2k, edge_mode, exposure_start, exposure_end;
    logic      charge_xfer, exposure_active_out, underrun;
    dpv_pair_t pix_pair;
    dpv_link_t link_out;
    int        len_last, lines, bad, error_cnt, n_tests;

    dpv_line_out dut (.mclk(mclk), .arst_n(arst_n), .pix_clk(pix_clk), .line_acq_done(line_acq_done),
        .pix_pair(pix_pair), .pix_valid(pix_valid), .pix_ready(pix_ready), .depth8(depth8),
        .sensor_2k(sensor_2k), .edge_mode(edge_mode), .exposure_start(exposure_start),
        .exposure_end(exposure_end), .charge_xfer(charge_xfer),
        .exposure_active_out(exposure_active_out), .link_out(link_out), .underrun(underrun));

    dpv_grabber grab (.pix_clk(pix_clk), .arst_n(arst_n), .link(link_out), .mode8(depth8),
        .len_last(len_last), .lines(lines), .bad(bad));

    // Clocks: 50 MHz system clock, 30 ns link clock offset so edges never meet.
    always #10 mclk = ~mclk;
    initial begin
        pix_clk = 1'b0;
        #3;
        forever #15 pix_clk = ~pix_clk;
    end

    // Ends the run with the counts and the verdict.
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Offers pairs k = 0..n-1 as pixels 2k+1 and 2k+2, holding each until taken.
    task automatic feed(input int n);
        int   i, g;
        logic r;
        i = 0; g = 0; r = 1'b0;
        while (i < n && g < 20000) begin
            @(negedge mclk);
            if (pix_valid && r) i++;
            g++;
            r = pix_ready;
            pix_valid = (i < n);
            pix_pair.first = 10'((2 * i + 1) * 7);
            pix_pair.second = 10'((2 * i + 2) * 7);
        end
        if (g >= 20000) begin error_cnt++; close_out(); end
    endtask

    // Sends one line: data waits in the FIFO until acquisition is done, then the line is judged.
    task automatic send_line(input logic big, input logic m8);
        int   n, g, l0;
        n = big ? 1024 : 512;
        l0 = lines;
        @(negedge mclk);
        sensor_2k = big;
        depth8 = m8;
        fork
            feed(n);
            begin
                repeat (60) @(negedge mclk);
                `CHK(link_out.line_valid, 1'b0)
                `CHK(pix_ready, 1'b0)
                line_acq_done = 1'b1;
                @(negedge mclk);
                line_acq_done = 1'b0;
                g = 0;
                while (lines == l0 && g < 4000) begin @(negedge mclk); g++; end
                if (g >= 4000) begin error_cnt++; close_out(); end
            end
        join
        `CHK(len_last, n)
        `CHK(bad, 0)
        `CHK(link_out.line_valid, 1'b0)
        `CHK(underrun, 1'b0)
    endtask

    // Pulses one exposure control input and checks the pin two cycles later.
    task automatic expo(input logic st, input logic en, input logic exp);
        @(negedge mclk);
        exposure_start = st;
        exposure_end = en;
        @(negedge mclk);
        exposure_start = 1'b0;
        exposure_end = 1'b0;
        @(negedge mclk);
        `CHK(exposure_active_out, exp)
    endtask

    // Exposure before any line stays low; afterwards it follows start, end and charge transfer.
    task automatic check_expo(input logic after_line);
        edge_mode = 1'b1;
        charge_xfer = 1'b0;
        expo(1'b1, 1'b0, after_line);
        if (after_line) begin
            charge_xfer = 1'b1;
            expo(1'b0, 1'b0, 1'b0);
            edge_mode = 1'b0;
            expo(1'b0, 1'b0, 1'b1);
            charge_xfer = 1'b0;
        end
        expo(1'b0, 1'b1, 1'b0);
    endtask

    // Main sequence: reset, quiet link, exposure gate, 1K 10-bit, 2K 8-bit, exposure.
    initial begin
        mclk = 1'b0; arst_n = 1'b0; line_acq_done = 1'b0; pix_valid = 1'b0;
        pix_pair = '0; depth8 = 1'b0; sensor_2k = 1'b0; edge_mode = 1'b0;
        exposure_start = 1'b0; exposure_end = 1'b0; charge_xfer = 1'b0;
        error_cnt = 0; n_tests = 0;
        repeat (6) @(negedge mclk);
        `CHK(link_out, 22'h000000)
        `CHK(exposure_active_out, 1'b0)
        arst_n = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK(link_out.line_valid, 1'b0)
        check_expo(1'b0);
        send_line(1'b0, 1'b0);
        send_line(1'b1, 1'b1);
        `CHK(lines, 2)
        check_expo(1'b1);
        close_out();
    end
endmodule
`default_nettype wire
